/* hdl/pmrc_pkg.sv */
// Package: constants, types and register map of the power mode and retention controller
package pmrc_pkg;

	// ****************************************
	// Register offsets (byte addresses = 4 * index)
	// ****************************************
	localparam logic [7:0] IDX_TEMPERATURE_RESULT = 8'hd7;
	localparam logic [7:0] IDX_BATTERY_RESULT = 8'hdf;
	localparam logic [7:0] IDX_SUPPLY_INPUT_RESULT = 8'hef;
	localparam logic [7:0] IDX_CHANGE_THRESHOLD_CFG = 8'hf3;
	localparam logic [7:0] IDX_PERIPHERAL_CFG = 8'hf4;
	localparam logic [7:0] IDX_SWITCHOVER_CFG = 8'hf5;
	localparam logic [7:0] IDX_CONVERTER_STROBE_PERIOD = 8'hf9;
	localparam logic [7:0] IDX_BATTERY_LOW_THRESHOLD = 8'hfa;
	localparam logic [7:0] IDX_RETAINED_SCRATCH_A = 8'hfb;
	localparam logic [7:0] IDX_RETAINED_SCRATCH_B = 8'hfc;
	localparam logic [7:0] IDX_RETAINED_SCRATCH_C = 8'hfd;
	localparam logic [7:0] IDX_RETAINED_SCRATCH_D = 8'hfe;
	localparam logic [7:0] IDX_INTERRUPT_PIN_CFG = 8'hff;
	// Own registers
	localparam logic [7:0] IDX_MODE_CTRL = 8'hc0;
	localparam logic [7:0] IDX_MODE_STATUS = 8'hc1;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'hc2;
	localparam logic [7:0] IDX_IRQ_MASK = 8'hc3;
	localparam logic [7:0] IDX_METERING_MODE = 8'h0b;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int SUPPLY_SOURCE_BIT = 6;
	localparam int METERING_POWER_DOWN_BIT = 4;
	localparam int CTRL_SLEEP_REQ_BIT = 0;
	localparam int CTRL_SOFT_RESET_BIT = 1;
	localparam int CTRL_WAKE_BIT = 2;
	localparam int IRQ_SWITCH_BAT = 0;
	localparam int IRQ_RESTORE = 1;
	localparam int IRQ_WAKE = 2;
	localparam int IRQ_W = 3;

	// ****************************************
	// Reset values and timing
	// ****************************************
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_PERIPHERAL_CFG = 8'h40;
	localparam int CORE_CLOCK_KHZ = 1024;
	localparam int CORE_RESET_NS = 500;
	localparam int HCLK_NS = 50;
	localparam int CORE_RESET_CYCLES = (CORE_RESET_NS + HCLK_NS - 1) / HCLK_NS;

	typedef enum logic [1:0] {
		HTRANS_IDLE = 2'b00,
		HTRANS_NONSEQ = 2'b10
	} pmrc_htrans_e;

	typedef enum {
		MODE_NORMAL,
		MODE_BATTERY,
		MODE_SLEEP
	} pmrc_mode_e;

	// Rail enables presented to the supply switch and domains
	typedef struct packed {
		logic switched_from_main;
		logic internal_analog_rail_en;
		logic internal_digital_rail_en;
		logic core_en;
		logic metering_analog_en;
	} pmrc_rails_s;

	// Enables of the always-on 3.3 V peripherals
	typedef struct packed {
		logic temperature_conv_en;
		logic supply_conv_en;
		logic rtc_en;
		logic display_en;
	} pmrc_aon_s;

	typedef logic [7:0] pmrc_byte_t;

endpackage : pmrc_pkg

/* hdl/pmrc_ctrl.sv */
// Power mode sequencer with retained register file and AHB-Lite slave
// Function
// - Normal mode: supply from main, rails on
// - Reset sets core clock to 1.024 MHz
// - Battery mode: battery supply, metering analog off
// - Return to main when above 2.75V, power-down clear
// - Sleep: battery supply, 2.5V rails and core off
// - RAM marked invalid after sleep
// - Sleep exit restarts from reset vector
// - 3.3V peripherals stay on, individually enabled
// - Sleep lasts until a wake event
// - Four scratch registers retained through sleep
// - Listed configuration registers retained through sleep
// - Core clock setting not retained; restarts at default after sleep
// - Peripheral cfg bit 6 shows supply source
// - Supply restore wakes sleep without mask
// - Reset pin low in sleep wakes to battery
`timescale 1ns/1ns
module pmrc_ctrl #(
	parameter int CORE_RESET_LEN = pmrc_pkg::CORE_RESET_CYCLES
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Supply sensing and wake
	input wire logic main_above_threshold,
	input wire logic main_fail,
	input wire logic reset_pin_n,
	input wire logic peripheral_wake,
	// Analog results from always-on converters
	input wire logic [7:0] temperature_value,
	input wire logic [7:0] battery_value,
	input wire logic [7:0] supply_input_value,
	input wire logic results_valid,
	// Power control outputs
	output pmrc_pkg::pmrc_rails_s rails,
	output pmrc_pkg::pmrc_aon_s aon_en,
	output logic core_reset_n,
	output logic ram_invalid,
	output logic [15:0] core_clock_khz,
	output logic [1:0] mode_code,
	output logic irq
);

	// The core reset counter is eight bits wide and must count at least one cycle
	if (CORE_RESET_LEN < 1 || CORE_RESET_LEN > 255) begin : g_reset_len_check
		$error("CORE_RESET_LEN out of range");
	end

	// ****************************************
	// Bus address phase capture
	// ****************************************
	logic wr_pend_r;
	logic rd_pend_r;
	logic [7:0] idx_r;
	logic access;
	assign access = hsel && hready && htrans == pmrc_pkg::HTRANS_NONSEQ;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			idx_r <= 8'h00;
		end else begin
			wr_pend_r <= access && hwrite;
			rd_pend_r <= access && !hwrite;
			idx_r <= haddr[9:2];
		end
	end

	function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
		hit = a == b;
	endfunction : hit

	logic wr_now;
	logic [7:0] wd;
	assign wr_now = wr_pend_r;
	assign wd = hwdata[7:0];

	// ****************************************
	// Mode state machine (always-on)
	// ****************************************
	pmrc_pkg::pmrc_mode_e mode_r;
	pmrc_pkg::pmrc_mode_e mode_nxt;
	logic [7:0] metering_mode_r;
	logic [7:0] mode_ctrl_r;
	logic sleep_req;
	logic soft_reset_req;
	logic sleep_exit;
	assign sleep_req = wr_now && hit(idx_r, pmrc_pkg::IDX_MODE_CTRL) && wd[pmrc_pkg::CTRL_SLEEP_REQ_BIT];
	assign soft_reset_req = wr_now && hit(idx_r, pmrc_pkg::IDX_MODE_CTRL) && wd[pmrc_pkg::CTRL_SOFT_RESET_BIT];

	always_comb begin
		mode_nxt = mode_r;
		case (mode_r)
			pmrc_pkg::MODE_NORMAL: begin
				if (main_fail) begin
					mode_nxt = pmrc_pkg::MODE_BATTERY;
				end
			end
			pmrc_pkg::MODE_BATTERY: begin
				if (main_above_threshold && !metering_mode_r[pmrc_pkg::METERING_POWER_DOWN_BIT]) begin
					mode_nxt = pmrc_pkg::MODE_NORMAL;
				end else if (sleep_req) begin
					mode_nxt = pmrc_pkg::MODE_SLEEP;
				end
			end
			pmrc_pkg::MODE_SLEEP: begin
				// Restore needs no mask; reset pin and enabled peripherals wake to battery
				if (main_above_threshold) begin
					mode_nxt = pmrc_pkg::MODE_NORMAL;
				end else if (!reset_pin_n || peripheral_wake) begin
					mode_nxt = pmrc_pkg::MODE_BATTERY;
				end
			end
			default: mode_nxt = pmrc_pkg::MODE_NORMAL;
		endcase
	end

	assign sleep_exit = mode_r == pmrc_pkg::MODE_SLEEP && mode_nxt != pmrc_pkg::MODE_SLEEP;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_r <= pmrc_pkg::MODE_NORMAL;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	// ****************************************
	// Core domain reset and RAM validity
	// ****************************************
	logic [7:0] core_rst_cnt_r;
	logic ram_invalid_r;
	logic core_live;
	assign core_live = mode_r != pmrc_pkg::MODE_SLEEP;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			core_rst_cnt_r <= 8'(CORE_RESET_LEN);
		end else if (!core_live || sleep_exit || soft_reset_req) begin
			// Held through sleep so the core restarts at its reset vector
			core_rst_cnt_r <= 8'(CORE_RESET_LEN);
		end else if (core_rst_cnt_r != 8'h00) begin
			core_rst_cnt_r <= core_rst_cnt_r - 8'h01;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ram_invalid_r <= 1'b1;
		end else if (!core_live) begin
			ram_invalid_r <= 1'b1;
		end else if (wr_now && hit(idx_r, pmrc_pkg::IDX_MODE_CTRL) && wd[pmrc_pkg::CTRL_WAKE_BIT]) begin
			ram_invalid_r <= 1'b0;
		end
	end

	assign core_reset_n = core_rst_cnt_r == 8'h00;
	assign ram_invalid = ram_invalid_r;
	// Reset clock divider state; the core domain clock setting restarts at default
	assign core_clock_khz = 16'(pmrc_pkg::CORE_CLOCK_KHZ);

	// ****************************************
	// Rail control
	// ****************************************
	always_comb begin
		rails = '0;
		case (mode_r)
			pmrc_pkg::MODE_NORMAL: begin
				rails = '1;
			end
			pmrc_pkg::MODE_BATTERY: begin
				rails.internal_analog_rail_en = 1'b1;
				rails.internal_digital_rail_en = 1'b1;
				rails.core_en = 1'b1;
			end
			pmrc_pkg::MODE_SLEEP: begin
				rails = '0;
			end
			default: rails = '0;
		endcase
	end

	always_comb begin
		case (mode_r)
			pmrc_pkg::MODE_NORMAL: mode_code = 2'h0;
			pmrc_pkg::MODE_BATTERY: mode_code = 2'h1;
			pmrc_pkg::MODE_SLEEP: mode_code = 2'h2;
			default: mode_code = 2'h0;
		endcase
	end

	// ****************************************
	// Retained registers: never touched by a core reset
	// ****************************************
	logic [7:0] scratch_r [4];
	logic [7:0] change_threshold_cfg_r;
	logic [7:0] peripheral_cfg_r;
	logic [7:0] switchover_cfg_r;
	logic [7:0] converter_strobe_period_r;
	logic [7:0] battery_low_threshold_r;
	logic [7:0] interrupt_pin_cfg_r;
	logic [7:0] temperature_result_r;
	logic [7:0] battery_result_r;
	logic [7:0] supply_input_result_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 4; i++) begin
				scratch_r[i] <= pmrc_pkg::RST_ZERO;
			end
		end else if (wr_now && idx_r >= pmrc_pkg::IDX_RETAINED_SCRATCH_A && idx_r <= pmrc_pkg::IDX_RETAINED_SCRATCH_D) begin
			scratch_r[2'(idx_r - pmrc_pkg::IDX_RETAINED_SCRATCH_A)] <= wd;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			change_threshold_cfg_r <= pmrc_pkg::RST_ZERO;
			peripheral_cfg_r <= pmrc_pkg::RST_PERIPHERAL_CFG;
			switchover_cfg_r <= pmrc_pkg::RST_ZERO;
			converter_strobe_period_r <= pmrc_pkg::RST_ZERO;
			battery_low_threshold_r <= pmrc_pkg::RST_ZERO;
			interrupt_pin_cfg_r <= pmrc_pkg::RST_ZERO;
			metering_mode_r <= pmrc_pkg::RST_ZERO;
		end else if (wr_now) begin
			// Written only by bus; sleep and core reset leave them intact
			case (idx_r)
				pmrc_pkg::IDX_CHANGE_THRESHOLD_CFG: change_threshold_cfg_r <= wd;
				pmrc_pkg::IDX_PERIPHERAL_CFG: peripheral_cfg_r <= wd;
				pmrc_pkg::IDX_SWITCHOVER_CFG: switchover_cfg_r <= wd;
				pmrc_pkg::IDX_CONVERTER_STROBE_PERIOD: converter_strobe_period_r <= wd;
				pmrc_pkg::IDX_BATTERY_LOW_THRESHOLD: battery_low_threshold_r <= wd;
				pmrc_pkg::IDX_INTERRUPT_PIN_CFG: interrupt_pin_cfg_r <= wd;
				pmrc_pkg::IDX_METERING_MODE: metering_mode_r <= wd;
				default: ;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			temperature_result_r <= pmrc_pkg::RST_ZERO;
			battery_result_r <= pmrc_pkg::RST_ZERO;
			supply_input_result_r <= pmrc_pkg::RST_ZERO;
		end else if (results_valid) begin
			temperature_result_r <= temperature_value;
			battery_result_r <= battery_value;
			supply_input_result_r <= supply_input_value;
		end
	end

	// Peripheral enables from low bits of the retained peripheral cfg
	assign aon_en = pmrc_pkg::pmrc_aon_s'(peripheral_cfg_r[3:0]);

	// ****************************************
	// Interrupts: sticky, write one to clear, set wins
	// ****************************************
	logic [pmrc_pkg::IRQ_W-1:0] irq_status_r;
	logic [pmrc_pkg::IRQ_W-1:0] irq_mask_r;
	logic [pmrc_pkg::IRQ_W-1:0] irq_set;
	logic [pmrc_pkg::IRQ_W-1:0] irq_clr;
	always_comb begin
		irq_set = '0;
		irq_set[pmrc_pkg::IRQ_SWITCH_BAT] = mode_r == pmrc_pkg::MODE_NORMAL && mode_nxt == pmrc_pkg::MODE_BATTERY;
		irq_set[pmrc_pkg::IRQ_RESTORE] = mode_r != pmrc_pkg::MODE_NORMAL && mode_nxt == pmrc_pkg::MODE_NORMAL;
		irq_set[pmrc_pkg::IRQ_WAKE] = sleep_exit;
	end
	assign irq_clr = (wr_now && hit(idx_r, pmrc_pkg::IDX_IRQ_STATUS)) ? wd[pmrc_pkg::IRQ_W-1:0] : '0;
	logic [pmrc_pkg::IRQ_W-1:0] irq_status_nxt;
	assign irq_status_nxt = (irq_status_r & ~irq_clr) | irq_set;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_status_r <= '0;
		end else begin
			irq_status_r <= irq_status_nxt;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_mask_r <= '0;
		end else if (wr_now && hit(idx_r, pmrc_pkg::IDX_IRQ_MASK)) begin
			irq_mask_r <= wd[pmrc_pkg::IRQ_W-1:0];
		end
	end

	assign irq = |(irq_status_r & irq_mask_r);

	// ****************************************
	// Read data
	// ****************************************
	// Read data is captured at the address phase edge, so it stands as a flop output
	// through the whole data phase with no wait state
	logic [7:0] rd_idx;
	logic [7:0] rd;
	logic [7:0] rd_fwd;
	assign rd_idx = haddr[9:2];

	always_comb begin
		rd = 8'h00;
		case (rd_idx)
			pmrc_pkg::IDX_TEMPERATURE_RESULT: rd = temperature_result_r;
			pmrc_pkg::IDX_BATTERY_RESULT: rd = battery_result_r;
			pmrc_pkg::IDX_SUPPLY_INPUT_RESULT: rd = supply_input_result_r;
			pmrc_pkg::IDX_CHANGE_THRESHOLD_CFG: rd = change_threshold_cfg_r;
			pmrc_pkg::IDX_PERIPHERAL_CFG: begin
				rd = peripheral_cfg_r;
				rd[pmrc_pkg::SUPPLY_SOURCE_BIT] = mode_r == pmrc_pkg::MODE_NORMAL;
			end
			pmrc_pkg::IDX_SWITCHOVER_CFG: rd = switchover_cfg_r;
			pmrc_pkg::IDX_CONVERTER_STROBE_PERIOD: rd = converter_strobe_period_r;
			pmrc_pkg::IDX_BATTERY_LOW_THRESHOLD: rd = battery_low_threshold_r;
			pmrc_pkg::IDX_RETAINED_SCRATCH_A, pmrc_pkg::IDX_RETAINED_SCRATCH_B,
			pmrc_pkg::IDX_RETAINED_SCRATCH_C, pmrc_pkg::IDX_RETAINED_SCRATCH_D:
				rd = scratch_r[2'(rd_idx - pmrc_pkg::IDX_RETAINED_SCRATCH_A)];
			pmrc_pkg::IDX_INTERRUPT_PIN_CFG: rd = interrupt_pin_cfg_r;
			pmrc_pkg::IDX_METERING_MODE: rd = metering_mode_r;
			pmrc_pkg::IDX_MODE_STATUS: rd = {5'h00, ram_invalid_r, mode_code};
			pmrc_pkg::IDX_IRQ_STATUS: rd = {5'h00, irq_status_nxt};
			pmrc_pkg::IDX_IRQ_MASK: rd = {5'h00, irq_mask_r};
			default: rd = 8'h00;
		endcase
	end

	// A write ending at the capture edge to the same index is forwarded, so a read right
	// behind a write sees the new contents; mode status may lag a control write by a cycle
	always_comb begin
		rd_fwd = rd;
		if (wr_now && idx_r == rd_idx) begin
			case (rd_idx)
				pmrc_pkg::IDX_CHANGE_THRESHOLD_CFG, pmrc_pkg::IDX_SWITCHOVER_CFG,
				pmrc_pkg::IDX_CONVERTER_STROBE_PERIOD, pmrc_pkg::IDX_BATTERY_LOW_THRESHOLD,
				pmrc_pkg::IDX_RETAINED_SCRATCH_A, pmrc_pkg::IDX_RETAINED_SCRATCH_B,
				pmrc_pkg::IDX_RETAINED_SCRATCH_C, pmrc_pkg::IDX_RETAINED_SCRATCH_D,
				pmrc_pkg::IDX_INTERRUPT_PIN_CFG, pmrc_pkg::IDX_METERING_MODE: begin
					rd_fwd = wd;
				end
				pmrc_pkg::IDX_PERIPHERAL_CFG: begin
					rd_fwd = wd;
					rd_fwd[pmrc_pkg::SUPPLY_SOURCE_BIT] = rd[pmrc_pkg::SUPPLY_SOURCE_BIT];
				end
				pmrc_pkg::IDX_IRQ_MASK: begin
					rd_fwd = {5'h00, wd[pmrc_pkg::IRQ_W-1:0]};
				end
				default: rd_fwd = rd;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (access && !hwrite) begin
			hrdata <= {24'h00_0000, rd_fwd};
		end
	end

endmodule : pmrc_ctrl

/* test/pmrc_ctrl_props.sv */
// Checker of mode, rail and core reset behaviour at the controller ports
`timescale 1ns/1ns
module pmrc_ctrl_props #(
	parameter int CORE_RESET_LEN = 10
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Observed ports
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic main_above_threshold,
	input wire logic reset_pin_n,
	input wire logic peripheral_wake,
	input wire pmrc_pkg::pmrc_rails_s rails,
	input wire logic core_reset_n,
	input wire logic ram_invalid,
	input wire logic [15:0] core_clock_khz,
	input wire logic [1:0] mode_code
);
	// ********
	// Helper
	// ********
	int low_cnt_r;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Sleep holds the core off for any time, so only the awake part is counted
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) low_cnt_r <= 0;
		else low_cnt_r <= (core_reset_n || mode_code == 2'h2) ? 0 : low_cnt_r + 1;
	end
	AST_CLOCK: assert property (core_clock_khz == 16'h0400) else $error("core clock not default");
	AST_NORMAL_RAILS: assert property (mode_code == 2'h0 |-> rails[4:1] == 4'hf)
		else $error("normal mode rails wrong");
	AST_BATTERY_RAILS: assert property (mode_code == 2'h1 |->
		!rails.switched_from_main && rails.core_en && !rails.metering_analog_en) else $error("battery rails wrong");
	AST_SLEEP_RAILS: assert property (mode_code == 2'h2 |-> rails == 5'h00) else $error("sleep rails on");
	AST_SLEEP_HOLD: assert property (mode_code == 2'h2 && !main_above_threshold && reset_pin_n &&
		!peripheral_wake |=> mode_code == 2'h2) else $error("sleep left without wake");
	AST_PIN_WAKE: assert property (mode_code == 2'h2 && !main_above_threshold && !reset_pin_n
		|-> ##[1:4] mode_code == 2'h1) else $error("reset pin did not wake to battery");
	AST_EXIT_RESET: assert property (mode_code == 2'h2 ##1 mode_code != 2'h2
		|-> ##[0:1] (!core_reset_n && ram_invalid)) else $error("no core reset on wake");
	AST_RESET_LEN: assert property ($rose(core_reset_n) |->
		low_cnt_r >= CORE_RESET_LEN - 1 && low_cnt_r <= CORE_RESET_LEN + 1) else $error("core reset length");
	AST_STAY_BATTERY: assert property (mode_code == 2'h1 && !main_above_threshold |=> mode_code != 2'h0)
		else $error("left battery without supply");
	AST_OKAY: assert property (hreadyout && !hresp) else $error("bus response not okay");
	COV_SLEEP_PIN: cover property (mode_code == 2'h2 ##1 mode_code == 2'h1);
	COV_SLEEP_RESTORE: cover property (mode_code == 2'h2 ##1 mode_code == 2'h0);
	COV_SWITCH: cover property (mode_code == 2'h0 ##1 mode_code == 2'h1);
	COV_CORE_RUN: cover property ($rose(core_reset_n));
endmodule : pmrc_ctrl_props

/* test/pmrc_supply_model.sv */
// Behavioural supply switch: main sense follows the supply with a settling delay
`timescale 1ns/1ns
module pmrc_supply_model #(
	parameter int SETTLE = 6
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Supply control
	input wire logic supply_on,
	// Sense outputs
	output logic main_fail,
	output logic main_above_threshold
);
	int cnt_r;
	// Loss is seen at once, restore only after the rail has settled above threshold
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) cnt_r <= 0;
		else cnt_r <= supply_on ? (cnt_r < SETTLE ? cnt_r + 1 : cnt_r) : 0;
	end
	assign main_fail = !supply_on;
	assign main_above_threshold = supply_on && cnt_r >= SETTLE;
endmodule : pmrc_supply_model

/* test/pmrc_ctrl_tb.sv */
// Self-checking bench of the power mode and retention controller
`timescale 1ns/1ns
module pmrc_ctrl_tb;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = pmrc_pkg::HTRANS_IDLE;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic supply_on = 1'b1;
	logic reset_pin_n = 1'b1;
	logic peripheral_wake = 1'b0;
	logic results_valid = 1'b0;
	logic [7:0] res [0:2] = '{8'h00, 8'h00, 8'h00};
	logic [31:0] hrdata;
	logic hreadyout, hresp, main_fail, main_above_threshold, core_reset_n, ram_invalid, irq;
	pmrc_pkg::pmrc_rails_s rails;
	pmrc_pkg::pmrc_aon_s aon_en;
	logic [15:0] core_clock_khz;
	logic [1:0] mode_code;
	logic [7:0] scr [0:4];
	logic [7:0] ridx [0:2] = '{pmrc_pkg::IDX_TEMPERATURE_RESULT, pmrc_pkg::IDX_BATTERY_RESULT,
		pmrc_pkg::IDX_SUPPLY_INPUT_RESULT};
	logic [7:0] pcfg, q;
	int n_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	int seed = 27;
	always #25 hclk = ~hclk;
	pmrc_supply_model pmrc_supply_model_i (.hclk, .hresetn, .supply_on, .main_fail, .main_above_threshold);
	pmrc_ctrl #(.CORE_RESET_LEN(4)) pmrc_ctrl_i (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
		.hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .main_above_threshold,
		.main_fail, .reset_pin_n, .peripheral_wake, .temperature_value(res[0]), .battery_value(res[1]),
		.supply_input_value(res[2]), .results_valid, .rails, .aon_en, .core_reset_n, .ram_invalid,
		.core_clock_khz, .mode_code, .irq);
	// ********
	// Tasks
	// ********
	task final_report;
		if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : final_report
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task xfer(input logic [7:0] idx, input logic wr, input logic [7:0] d);
		@(posedge hclk);
		haddr <= {22'h0, idx, 2'b00};
		htrans <= pmrc_pkg::HTRANS_NONSEQ;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= pmrc_pkg::HTRANS_IDLE;
		hwrite <= 1'b0;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata[7:0];
	endtask : xfer
	task rdchk(input logic [7:0] idx, input logic [7:0] exp);
		xfer(idx, 1'b0, 8'h00);
		chk(q, exp);
	endtask : rdchk
	task wait_mode(input logic [1:0] m);
		repeat (300) if (mode_code !== m) @(posedge hclk);
		chk(mode_code, m);
	endtask : wait_mode
	task wait_core;
		repeat (300) if (core_reset_n !== 1'b1) @(posedge hclk);
		chk(core_reset_n, 1'b1);
	endtask : wait_core
	task retained(input logic [7:0] src);
		for (int i = 0; i < 4; i++) rdchk(8'(pmrc_pkg::IDX_RETAINED_SCRATCH_A + i), scr[i]);
		rdchk(pmrc_pkg::IDX_INTERRUPT_PIN_CFG, scr[4]);
		rdchk(pmrc_pkg::IDX_PERIPHERAL_CFG, pcfg | src);
		for (int i = 0; i < 3; i++) rdchk(ridx[i], res[i]);
	endtask : retained
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			final_report;
		end
	end
	// ********
	// Main sequence
	// ********
	initial begin
		repeat (4) @(posedge hclk);
		chk(rails, 5'h1f);
		chk(core_reset_n, 1'b0);
		hresetn <= 1'b1;
		wait_core;
		chk(core_clock_khz, 16'h0400);
		rdchk(pmrc_pkg::IDX_PERIPHERAL_CFG, pmrc_pkg::RST_PERIPHERAL_CFG);
		rdchk(8'h10, 8'h00);
		rdchk(pmrc_pkg::IDX_MODE_STATUS, 8'h04);
		// Soft core reset restarts the core domain at the default clock
		xfer(pmrc_pkg::IDX_MODE_CTRL, 1'b1, 8'h02);
		@(posedge hclk);
		chk(core_reset_n, 1'b0);
		wait_core;
		chk(core_clock_khz, 16'h0400);
		// Software prepares the always-on state while the core still runs
		for (int i = 0; i < 5; i++) scr[i] = $random(seed);
		for (int i = 0; i < 4; i++) xfer(8'(pmrc_pkg::IDX_RETAINED_SCRATCH_A + i), 1'b1, scr[i]);
		xfer(pmrc_pkg::IDX_INTERRUPT_PIN_CFG, 1'b1, scr[4]);
		pcfg = $random(seed) & 8'h0f;
		xfer(pmrc_pkg::IDX_PERIPHERAL_CFG, 1'b1, pcfg | 8'h40);
		@(posedge hclk);
		chk(aon_en, pcfg[3:0]);
		for (int i = 0; i < 3; i++) res[i] <= $random(seed);
		results_valid <= 1'b1;
		@(posedge hclk);
		results_valid <= 1'b0;
		xfer(pmrc_pkg::IDX_IRQ_MASK, 1'b1, 8'h07);
		supply_on <= 1'b0;
		wait_mode(2'h1);
		chk(irq, 1'b1);
		rdchk(pmrc_pkg::IDX_IRQ_STATUS, 8'h01);
		xfer(pmrc_pkg::IDX_IRQ_STATUS, 1'b1, 8'h01);
		@(posedge hclk);
		chk(irq, 1'b0);
		// Metering kept powered down holds battery mode with the supply back
		xfer(pmrc_pkg::IDX_METERING_MODE, 1'b1, 8'h10);
		supply_on <= 1'b1;
		repeat (30) @(posedge hclk);
		chk(mode_code, 2'h1);
		supply_on <= 1'b0;
		xfer(pmrc_pkg::IDX_MODE_CTRL, 1'b1, 8'h01);
		wait_mode(2'h2);
		chk(rails, 5'h00);
		repeat (40) @(posedge hclk);
		chk(mode_code, 2'h2);
		reset_pin_n <= 1'b0;
		wait_mode(2'h1);
		chk(ram_invalid, 1'b1);
		reset_pin_n <= 1'b1;
		wait_core;
		retained(8'h00);
		rdchk(pmrc_pkg::IDX_MODE_STATUS, 8'h05);
		xfer(pmrc_pkg::IDX_MODE_CTRL, 1'b1, 8'h04);
		rdchk(pmrc_pkg::IDX_MODE_STATUS, 8'h01);
		rdchk(pmrc_pkg::IDX_IRQ_STATUS, 8'h04);
		xfer(pmrc_pkg::IDX_IRQ_MASK, 1'b1, 8'h07);
		xfer(pmrc_pkg::IDX_IRQ_STATUS, 1'b1, 8'h07);
		@(posedge hclk);
		chk(irq, 1'b0);
		// An enabled peripheral event also ends sleep, into battery mode
		xfer(pmrc_pkg::IDX_MODE_CTRL, 1'b1, 8'h01);
		wait_mode(2'h2);
		peripheral_wake <= 1'b1;
		wait_mode(2'h1);
		peripheral_wake <= 1'b0;
		wait_core;
		// Supply restore ends sleep straight into normal mode
		xfer(pmrc_pkg::IDX_METERING_MODE, 1'b1, 8'h00);
		xfer(pmrc_pkg::IDX_MODE_CTRL, 1'b1, 8'h01);
		wait_mode(2'h2);
		supply_on <= 1'b1;
		wait_mode(2'h0);
		wait_core;
		retained(8'h40);
		final_report;
	end
endmodule : pmrc_ctrl_tb
bind pmrc_ctrl pmrc_ctrl_props #(.CORE_RESET_LEN(CORE_RESET_LEN)) pmrc_ctrl_props_i (.hclk, .hresetn, .hreadyout,
	.hresp, .main_above_threshold, .reset_pin_n, .peripheral_wake, .rails, .core_reset_n, .ram_invalid,
	.core_clock_khz, .mode_code);
